// ==== hw/rtc_core_defs.vh ====
// Register offsets, field positions, reset values and timing constants of the clock core
`ifndef RTC_CORE_DEFS_VH
`define RTC_CORE_DEFS_VH

`define OFF_SEC 8'h00
`define OFF_MIN 8'h04
`define OFF_HOUR 8'h08
`define OFF_DATE 8'h0C
`define OFF_MONTH 8'h10
`define OFF_YEAR 8'h14
`define OFF_DOW 8'h18
`define OFF_CTRL 8'h1C
`define OFF_STATUS 8'h20
`define OFF_ALM_BASE 8'h24
`define OFF_ALM_LAST 8'h3C
`define OFF_ALM_MASK 8'h40

`define CTRL_ALM_EN 0
`define CTRL_REPEAT 1
`define CTRL_FO_LSB 4
`define CTRL_FO_MSB 7
`define STAT_ALM 0
`define STAT_FAIL 1
`define STAT_BACKUP 2

`define RST_DATE 7'h01
`define RST_MONTH 7'h01
`define RST_CTRL 8'h00

`define OSC_HZ 32768
`define PCLK_HZ 10000000
`define ALARM_PULSE_MS 250
`define LAST_YEAR 7'h63

`endif

// ==== hw/rtc_calendar_alarm_core.v ====
// Clock, calendar, alarm and frequency-output core with an APB register slave
//
// Functional notes
// - Separate counters for time and calendar
// - Calendar valid through 2099 with leap years
// - Time base counts 32.768 kHz oscillator edges
// - Alarm can match any clock/calendar field
// - Match sets pollable flag, optional interrupt
// - Repeat mode alarms on every periodic match
// - Backup supply switching automatic, clock keeps running
// - Frequency-select field chooses pin function
// - Interrupt mode: open-drain active-low request
// - Frequency mode: oscillator (select 1) or divided oscillator, open-drain
// - Bus clock clocks all data in/out
// - Bus clock input ignored on backup; the core still answers each access, with pslverr set
// - Bus data input active in normal mode
// - No bus transfer possible on backup
// - Bus timing up to 400 kHz; the core assumes a 10 MHz bus clock (PCLK_HZ)
// - Single mode: pin low, flag set
// - Pulsed mode: pin low 250 ms
// - Frequency output disables the alarm
// - Clock frozen until first time write
`timescale 1ns/100ps
`include "rtc_core_defs.vh"

module rtc_calendar_alarm_core #(
	parameter TICKS_PER_SEC = `OSC_HZ,
	parameter PULSE_CYCLES = `ALARM_PULSE_MS * (`PCLK_HZ / 1000)
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire osc_input_pin,
	input wire on_backup,
	output reg alarm_or_freq_pin_o,
	output reg alarm_or_freq_pin_oe
);

	// Synchronisers for pin inputs
	reg osc_s1_r;
	reg osc_s2_r;
	reg osc_d_r;
	reg bak_s1_r;
	reg bak_s2_r;

	// Time and calendar
	reg [6:0] sec_r;
	reg [6:0] min_r;
	reg [6:0] hour_r;
	reg [6:0] date_r;
	reg [6:0] month_r;
	reg [6:0] year_r;
	reg [6:0] dow_r;
	reg [15:0] presc_r;
	reg [14:0] div_r;

	// Control and status
	reg [7:0] ctrl_r;
	reg alm_flag_r;
	reg fail_r;
	reg [6:0] alm_r [0:6];
	reg [6:0] amask_r;
	reg check_r;
	reg [21:0] pulse_r;

	wire osc_rise;
	wire sec_tick;
	wire access;
	wire wr_en;
	wire time_wr;
	wire alm_wr;
	wire [2:0] alm_idx;
	wire [3:0] fo_sel;
	wire freq_mode;
	wire alarm_live;
	wire [48:0] cur_f;
	wire [6:0] hit;
	wire match;
	wire freq_lvl;
	wire [4:0] mdays;
	reg [31:0] rd_nxt;
	reg err_nxt;
	reg oe_nxt;

	// Terminal counts, cut to the counter widths
	localparam integer TICK_LAST_I = TICKS_PER_SEC - 1;
	localparam integer PULSE_LAST_I = PULSE_CYCLES - 1;
	localparam [15:0] TICK_LAST = TICK_LAST_I[15:0];
	localparam [21:0] PULSE_LAST = PULSE_LAST_I[21:0];

	assign osc_rise = osc_s2_r & ~osc_d_r;
	assign sec_tick = osc_rise && (presc_r == TICK_LAST) && !fail_r;
	// Bus accesses are refused while on the backup supply
	assign access = psel & penable & ~pready & ~bak_s2_r;
	// Refused addresses never write
	assign wr_en = access & pwrite & ~err_nxt;
	assign time_wr = wr_en && (paddr <= `OFF_DOW);
	assign alm_wr = wr_en && (paddr >= `OFF_ALM_BASE) && (paddr <= `OFF_ALM_LAST);
	assign alm_idx = paddr[4:2] - 3'h1;
	assign fo_sel = ctrl_r[`CTRL_FO_MSB:`CTRL_FO_LSB];
	assign freq_mode = (fo_sel != 4'h0);
	assign alarm_live = ctrl_r[`CTRL_ALM_EN] & ~freq_mode;
	assign cur_f = {year_r, dow_r, month_r, date_r, hour_r, min_r, sec_r};
	// Days in the current month
	assign mdays = (month_r == 7'h02) ? ((year_r[1:0] == 2'h0) ? 5'h1D : 5'h1C) :
		((month_r == 7'h04) || (month_r == 7'h06) || (month_r == 7'h09) ||
		(month_r == 7'h0B)) ? 5'h1E : 5'h1F;

	// One comparator per time field
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi = gi + 1) begin : g_cmp
			assign hit[gi] = ~amask_r[gi] | (cur_f[gi*7 +: 7] == alm_r[gi]);
		end
	endgenerate

	assign match = check_r && alarm_live && (amask_r != 7'h00) && (&hit);
	// Select 1 passes the oscillator, higher ones divide it
	assign freq_lvl = (fo_sel == 4'h1) ? osc_s2_r : div_r[fo_sel - 4'h2];

	// Register read mux and address check
	always @* begin
		rd_nxt = 32'h0000_0000;
		err_nxt = 1'b0;
		case (paddr)
			`OFF_SEC: rd_nxt[6:0] = sec_r;
			`OFF_MIN: rd_nxt[6:0] = min_r;
			`OFF_HOUR: rd_nxt[6:0] = hour_r;
			`OFF_DATE: rd_nxt[6:0] = date_r;
			`OFF_MONTH: rd_nxt[6:0] = month_r;
			`OFF_YEAR: rd_nxt[6:0] = year_r;
			`OFF_DOW: rd_nxt[6:0] = dow_r;
			`OFF_CTRL: rd_nxt[7:0] = ctrl_r;
			`OFF_STATUS: rd_nxt[2:0] = {bak_s2_r, fail_r, alm_flag_r};
			`OFF_ALM_MASK: rd_nxt[6:0] = amask_r;
			default: begin
				if ((paddr >= `OFF_ALM_BASE) && (paddr <= `OFF_ALM_LAST) &&
					(paddr[1:0] == 2'h0)) begin
					rd_nxt[6:0] = alm_r[alm_idx];
				end else begin
					err_nxt = 1'b1;
				end
			end
		endcase
		if (paddr[1:0] != 2'h0) begin
			err_nxt = 1'b1;
		end
	end

	// Pin drive: active low, released when idle
	always @* begin
		if (freq_mode) begin
			oe_nxt = ~freq_lvl;
		end else if (ctrl_r[`CTRL_REPEAT]) begin
			oe_nxt = (pulse_r != 22'h000000) || match;
		end else begin
			oe_nxt = alm_flag_r && ctrl_r[`CTRL_ALM_EN];
		end
	end

	// Input synchronisers and oscillator divider
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_d_r <= 1'b0;
			bak_s1_r <= 1'b0;
			bak_s2_r <= 1'b0;
			div_r <= 15'h0000;
		end else begin
			osc_s1_r <= osc_input_pin;
			osc_s2_r <= osc_s1_r;
			osc_d_r <= osc_s2_r;
			bak_s1_r <= on_backup;
			bak_s2_r <= bak_s1_r;
			if (osc_rise) begin
				div_r <= div_r + 15'h0001;
			end
		end
	end

	// APB answer: one wait state, all outputs registered
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & penable & ~pready;
			if (psel & penable & ~pready) begin
				pslverr <= err_nxt | bak_s2_r;
				prdata <= access ? rd_nxt : 32'h0000_0000;
			end else begin
				pslverr <= 1'b0;
				prdata <= 32'h0000_0000;
			end
		end
	end

	// Timekeeping counters; a host write takes priority over the tick
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_r <= 7'h00;
			min_r <= 7'h00;
			hour_r <= 7'h00;
			date_r <= `RST_DATE;
			month_r <= `RST_MONTH;
			year_r <= 7'h00;
			dow_r <= 7'h00;
			presc_r <= 16'h0000;
			fail_r <= 1'b1;
		end else if (time_wr) begin
			fail_r <= 1'b0;
			presc_r <= 16'h0000;
			case (paddr)
				`OFF_SEC: sec_r <= pwdata[6:0];
				`OFF_MIN: min_r <= pwdata[6:0];
				`OFF_HOUR: hour_r <= pwdata[6:0];
				`OFF_DATE: date_r <= pwdata[6:0];
				`OFF_MONTH: month_r <= pwdata[6:0];
				`OFF_YEAR: year_r <= pwdata[6:0];
				default: dow_r <= pwdata[6:0];
			endcase
		end else if (osc_rise && !fail_r) begin
			presc_r <= (presc_r == TICK_LAST) ? 16'h0000 : presc_r + 16'h0001;
			if (sec_tick) begin
				// Each field rolls over into the next
				sec_r <= (sec_r == 7'h3B) ? 7'h00 : sec_r + 7'h01;
				if (sec_r == 7'h3B) begin
					min_r <= (min_r == 7'h3B) ? 7'h00 : min_r + 7'h01;
					if (min_r == 7'h3B) begin
						hour_r <= (hour_r == 7'h17) ? 7'h00 : hour_r + 7'h01;
						if (hour_r == 7'h17) begin
							dow_r <= (dow_r == 7'h06) ? 7'h00 : dow_r + 7'h01;
							if (date_r[4:0] >= mdays) begin
								date_r <= 7'h01;
								if (month_r == 7'h0C) begin
									month_r <= 7'h01;
									year_r <= (year_r == `LAST_YEAR) ? 7'h00 :
										year_r + 7'h01;
								end else begin
									month_r <= month_r + 7'h01;
								end
							end else begin
								date_r <= date_r + 7'h01;
							end
						end
					end
				end
			end
		end
	end

	// Control, alarm registers and alarm status
	integer k;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `RST_CTRL;
			amask_r <= 7'h00;
			alm_flag_r <= 1'b0;
			check_r <= 1'b0;
			pulse_r <= 22'h000000;
			alarm_or_freq_pin_o <= 1'b0;
			alarm_or_freq_pin_oe <= 1'b0;
			for (k = 0; k < 7; k = k + 1) begin
				alm_r[k] <= 7'h00;
			end
		end else begin
			check_r <= sec_tick;
			alarm_or_freq_pin_o <= 1'b0;
			alarm_or_freq_pin_oe <= oe_nxt;
			if (wr_en && (paddr == `OFF_CTRL)) begin
				ctrl_r <= pwdata[7:0];
			end
			if (wr_en && (paddr == `OFF_ALM_MASK)) begin
				amask_r <= pwdata[6:0];
			end
			if (alm_wr) begin
				alm_r[alm_idx] <= pwdata[6:0];
			end
			// Match sets the flag; set wins over a same-cycle clear
			if (match) begin
				alm_flag_r <= 1'b1;
			end else if (wr_en && (paddr == `OFF_STATUS) && pwdata[`STAT_ALM]) begin
				alm_flag_r <= 1'b0;
			end
			if (match && ctrl_r[`CTRL_REPEAT]) begin
				pulse_r <= PULSE_LAST;
			end else if (pulse_r != 22'h000000) begin
				pulse_r <= pulse_r - 22'h000001;
			end
		end
	end

endmodule

// ==== verification/rtc_core_chk.sv ====
// Port checker for the clock core
`timescale 1ns/100ps
module rtc_core_chk #(
	parameter TICKS_PER_SEC = 4,
	parameter PULSE_CYCLES = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic osc_input_pin,
	input wire logic on_backup,
	input wire logic alarm_or_freq_pin_o,
	input wire logic alarm_or_freq_pin_oe
);
	logic [7:0] ctrl_r;
	logic [31:0] run_r;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= 8'h00;
			run_r <= 32'h0;
		end else begin
			if (psel && penable && !pready && pwrite && paddr == 8'h1C)
				ctrl_r <= pwdata[7:0];
			run_r <= alarm_or_freq_pin_oe ? run_r + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	bus_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("no answer");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	idle_data_a: assert property (!pready |-> prdata == 32'h0)
		else $error("stray read data");
	open_drain_a: assert property (alarm_or_freq_pin_o == 1'b0)
		else $error("pin driven high");
	backup_err_a: assert property (pready && $past(on_backup, 2) && $past(on_backup, 3)
		&& $past(on_backup, 4) && $past(on_backup, 5) |-> pslverr) else $error("backup access");
	err_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("data on refusal");
	alarm_off_a: assert property (ctrl_r == 8'h00 && $past(ctrl_r) == 8'h00
		|-> !alarm_or_freq_pin_oe) else $error("pin pulled while off");
	pulse_len_a: assert property ($fell(alarm_or_freq_pin_oe) && ctrl_r == 8'h03
		|-> run_r == PULSE_CYCLES) else $error("pulse length");
endmodule

bind rtc_calendar_alarm_core rtc_core_chk #(.TICKS_PER_SEC(TICKS_PER_SEC),
	.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .osc_input_pin(osc_input_pin), .on_backup(on_backup),
	.alarm_or_freq_pin_o(alarm_or_freq_pin_o), .alarm_or_freq_pin_oe(alarm_or_freq_pin_oe));

// ==== verification/rtc_pin_env.sv ====
// Oscillator source and pulled-up output pin around the clock core
`timescale 1ns/100ps
module rtc_pin_env (
	input wire logic run,
	input wire logic oe,
	output logic osc,
	output wire logic level
);
	assign level = oe ? 1'b0 : 1'b1; // Pull-up when released
	initial begin
		osc = 1'b0;
		forever #15259 osc = run ? ~osc : 1'b0; // 32.768 kHz source
	end
endmodule

// ==== verification/rtc_calendar_alarm_core_test.sv ====
// Testbench of the clock core
`timescale 1ns/100ps
module rtc_calendar_alarm_core_test;
	logic pclk, presetn, psel, penable, pwrite, on_backup, osc_run, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, rd;
	logic [31:0] prdata;
	logic pready, pslverr, pin_o, pin_oe, osc, pin;
	int miscompares, total_checks;
	rtc_calendar_alarm_core #(.TICKS_PER_SEC(4), .PULSE_CYCLES(20)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_input_pin(osc), .on_backup(on_backup), .alarm_or_freq_pin_o(pin_o),
		.alarm_or_freq_pin_oe(pin_oe));
	rtc_pin_env u_env (.run(osc_run), .oe(pin_oe), .osc(osc), .level(pin));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task wait_pin(input logic v);
		int n;
		n = 0;
		while (pin !== v && n < 4000) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task t_frozen;
		repeat (1500) @(posedge pclk);
		rdc(8'h00, 32'h0);
		rdc(8'h20, 32'h2);
		rdc(8'h0C, 32'h1);
		rdc(8'h10, 32'h1);
		apb(1'b0, 8'h44, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		apb(1'b0, 8'h25, 32'h0);
		chk(er, 1'b1);
	endtask
	task t_leap(input logic [7:0] y);
		apb(1'b1, 8'h14, {24'h0, y});
		apb(1'b1, 8'h10, 32'h2);
		apb(1'b1, 8'h0C, 32'h1C);
		apb(1'b1, 8'h08, 32'h17);
		apb(1'b1, 8'h04, 32'h3B);
		apb(1'b1, 8'h00, 32'h3B);
		repeat (1800) @(posedge pclk);
		rdc(8'h0C, y == 8'h60 ? 32'h1D : 32'h1);
		rdc(8'h10, y == 8'h60 ? 32'h2 : 32'h3);
		rdc(8'h08, 32'h0);
		rdc(8'h20, 32'h0);
	endtask
	task t_alarm(input logic [7:0] c);
		apb(1'b1, 8'h40, 32'h1);
		apb(1'b1, 8'h24, 32'h2);
		apb(1'b1, 8'h1C, {24'h0, c});
		rdc(8'h24, 32'h2);
		rdc(8'h40, 32'h1);
		rdc(8'h1C, {24'h0, c});
		apb(1'b1, 8'h00, 32'h0);
		wait_pin(1'b0);
		chk(pin, 1'b0);
		wait_pin(1'b1);
		chk(pin, c == 8'h01 ? 1'b0 : 1'b1);
		rdc(8'h20, 32'h1);
		apb(1'b1, 8'h20, 32'h1);
		repeat (3) @(posedge pclk);
		chk(pin, 1'b1);
	endtask
	task t_freq(input logic [7:0] c, input int lo, input int hi);
		int n;
		logic p;
		n = 0;
		apb(1'b1, 8'h1C, {24'h0, c});
		apb(1'b1, 8'h00, 32'h0);
		p = pin;
		repeat (3000) begin
			@(posedge pclk);
			n += (pin !== p);
			p = pin;
		end
		chk(n >= lo && n <= hi, 1'b1);
		rdc(8'h20, 32'h0);
		apb(1'b1, 8'h1C, 32'h0);
		repeat (3) @(posedge pclk);
		chk(pin, 1'b1);
	endtask
	task t_backup;
		apb(1'b1, 8'h00, 32'h0);
		on_backup <= 1'b1;
		repeat (1500) @(posedge pclk);
		apb(1'b0, 8'h00, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, 8'h08, 32'h5);
		chk(er, 1'b1);
		on_backup <= 1'b0;
		repeat (5) @(posedge pclk);
		rdc(8'h08, 32'h0);
		rdc(8'h00, 32'h1);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, on_backup} = '0;
		osc_run = 1'b1;
		presetn = 1'b0;
		miscompares = 0;
		total_checks = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_frozen;
		t_leap(8'h60);
		t_leap(8'h63);
		t_alarm(8'h01);
		t_alarm(8'h03);
		t_freq(8'h21, 9, 11);
		t_freq(8'h11, 18, 21);
		t_backup;
		close_out;
	end
	initial begin
		repeat (60000) @(posedge pclk);
		miscompares++;
		close_out;
	end
endmodule
